//--- verilog/ecc_encoder_counter_capture.sv
// Encoder counter with capture, serial position reader and register port
`timescale 1ns/100ps
// Behaviour
// - One interface works either as incremental counter or as serial absolute reader, set by configuration.
// - In incremental mode pulses count up or down by the decoded direction.
// - Counting stays idle until a preset has been loaded and counting has been enabled.
// - A configured external event copies the position into the capture register without disturbing counting.
// - Capture fires on the falling edge, the rising edge or both edges, as selected.
// - Input mode is normal or reverse with x1, x2 or x4; after reset it is normal x1.
// - A, B and Z each have a selectable filter from none to one millisecond, two microseconds by default.
// - Supply monitoring is switched by configuration and is off after reset.
// - In absolute mode the position is read from the encoder over the synchronous serial link.
module ecc_encoder_counter_capture
  import ecc_pkg::*;
#(
  parameter int FRAME_BITS = 8,
  parameter int FILT_500US_CYC = (FILT_500US_NS + CLK_NS - 1) / CLK_NS,
  parameter int FILT_1MS_CYC = (FILT_1MS_NS + CLK_NS - 1) / CLK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  input wire logic cap_in,
  input wire logic supply_ok,
  output logic ssi_clk,
  input wire logic ssi_data
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] preset;
    logic [31:0] count;
    logic [31:0] capt;
    logic [31:0] pos;
    logic [31:0] shreg;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic loaded;
    logic [2:0][FILT_CNT_W-1:0] fcnt;
    logic [2:0] fl;
    logic [2:0] fprev;
    logic cap_prev;
    ecc_ssi_t ssi;
    logic [SSI_DIV_W-1:0] div;
    logic [5:0] bitn;
    logic [SSI_GAP_W-1:0] gap;
    logic sclk;
    logic [31:0] rdata;
    logic irq;
  } ecc_state_t;

  ecc_state_t s;
  ecc_state_t n;
  logic [2:0] raw;
  logic [ST_W-1:0] set;
  logic [ST_W-1:0] clr;
  logic abs_mode;
  logic active;
  logic step;
  logic up;
  logic z_rise;
  logic cap_hit;
  logic tick;
  logic [31:0] cur;

  // Printed order of the filter choices is kept, not sorted
  function automatic int filt_cyc(input logic [3:0] sel);
    case (sel)
      4'h0: return 0;
      4'h1: return FILT_1US_CYC;
      4'h2: return FILT_2US_CYC;
      4'h3: return FILT_5US_CYC;
      4'h4: return FILT_50US_CYC;
      4'h5: return FILT_10US_CYC;
      4'h6: return FILT_80US_CYC;
      4'h7: return FILT_500US_CYC;
      default: return FILT_1MS_CYC;
    endcase
  endfunction : filt_cyc

  always_comb begin
    n = s;
    raw = {enc_z, enc_b, enc_a};
    set = '0;
    clr = '0;
    step = 1'b0;
    abs_mode = s.ctrl[CTRL_ABS];
    cur = abs_mode ? s.pos : s.count;
    // Debounce: any bounce restarts the hold count
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == s.fl[i]) begin
        n.fcnt[i] = '0;
      end else if (int'(s.fcnt[i]) + 1 >= filt_cyc(s.ctrl[CTRL_FILT_LO + 4 * i +: 4])) begin
        n.fl[i] = raw[i];
        n.fcnt[i] = '0;
      end else begin
        n.fcnt[i] = s.fcnt[i] + 16'h0001;
      end
    end
    n.fprev = s.fl;
    // Direction from old A against new B; reverse flips it
    up = ~(s.fprev[0] ^ s.fl[1]) ^ s.ctrl[CTRL_REV];
    case (s.ctrl[CTRL_MUL_LO +: 2])
      MUL_X4: step = (s.fl[0] ^ s.fprev[0]) | (s.fl[1] ^ s.fprev[1]);
      MUL_X2: step = s.fl[0] ^ s.fprev[0];
      default: step = s.fl[0] & ~s.fprev[0];
    endcase
    z_rise = s.fl[2] & ~s.fprev[2] & ~abs_mode;
    active = s.loaded & s.ctrl[CTRL_INIT] & ~abs_mode;
    if (z_rise) begin
      n.count = s.preset;
      n.loaded = 1'b1;
      set[ST_PRESET] = 1'b1;
    end else if (active && step) begin
      n.count = up ? s.count + 32'h0000_0001 : s.count - 32'h0000_0001;
    end
    // Capture input
    n.cap_prev = cap_in;
    case (s.ctrl[CTRL_EDGE_LO +: 2])
      EDGE_FALL: cap_hit = ~cap_in & s.cap_prev;
      EDGE_RISE: cap_hit = cap_in & ~s.cap_prev;
      EDGE_BOTH: cap_hit = cap_in ^ s.cap_prev;
      default: cap_hit = 1'b0;
    endcase
    if (cap_hit) begin
      n.capt = cur;
      set[ST_CAP] = 1'b1;
    end
    if (s.ctrl[CTRL_MON] && !supply_ok) begin
      set[ST_SUPPLY] = 1'b1;
    end
    // Serial reader: clock idles high, data taken on each rising edge
    tick = (s.div == SSI_DIV_W'(SSI_HALF_CYC - 1));
    n.div = tick ? '0 : s.div + 8'h01;
    case (s.ssi)
      SSI_IDLE: begin
        n.div = '0;
        n.bitn = '0;
        n.shreg = '0;
        if (abs_mode) begin
          n.ssi = SSI_LOW;
          n.sclk = 1'b0;
        end
      end
      SSI_LOW: begin
        if (tick) begin
          n.ssi = SSI_HIGH;
          n.sclk = 1'b1;
          n.shreg = {s.shreg[30:0], ssi_data};
        end
      end
      SSI_HIGH: begin
        if (tick) begin
          if (s.bitn == 6'(FRAME_BITS - 1)) begin
            n.ssi = SSI_GAP;
            n.gap = '0;
            n.pos = s.shreg;
            set[ST_FRAME] = 1'b1;
          end else begin
            n.bitn = s.bitn + 6'h01;
            n.ssi = SSI_LOW;
            n.sclk = 1'b0;
          end
        end
      end
      SSI_GAP: begin
        // Pause lets the encoder's monoflop expire before the next frame
        n.gap = s.gap + 11'h001;
        if (s.gap == SSI_GAP_W'(SSI_GAP_CYC - 1)) begin
          n.ssi = SSI_IDLE;
        end
      end
      default: n.ssi = SSI_IDLE;
    endcase
    if (!abs_mode) begin
      n.ssi = SSI_IDLE;
      n.sclk = 1'b1;
    end
    // Register port
    if (wr_en) begin
      if (addr == ADDR_CTRL) begin
        n.ctrl = wdata & CTRL_MASK;
      end else if (addr == ADDR_PRESET) begin
        n.preset = wdata;
      end else if (addr == ADDR_STAT) begin
        clr = wdata[ST_W-1:0];
      end else if (addr == ADDR_MASK) begin
        n.mask = wdata[ST_W-1:0];
      end
    end
    // New events win over a clear in the same cycle
    n.stat = (s.stat & ~clr) | set;
    n.irq = |(n.stat & n.mask);
    n.rdata = '0;
    if (rd_en) begin
      if (addr == ADDR_CTRL) begin
        n.rdata = s.ctrl;
      end else if (addr == ADDR_PRESET) begin
        n.rdata = s.preset;
      end else if (addr == ADDR_COUNT) begin
        n.rdata = cur;
      end else if (addr == ADDR_CAPT) begin
        n.rdata = s.capt;
      end else if (addr == ADDR_STAT) begin
        n.rdata = {28'h000_0000, s.stat};
      end else if (addr == ADDR_MASK) begin
        n.rdata = {28'h000_0000, s.mask};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.ssi <= SSI_IDLE;
      s.sclk <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign irq = s.irq;
  assign ssi_clk = s.sclk;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_mode_abs_frozen: assert property (abs_mode && $past(abs_mode) |=> $stable(s.count))
    else $error("count moved in absolute mode");

  a_count_step: assert property (active && step && !z_rise |=>
    s.count == ($past(up) ? $past(s.count) + 32'h0000_0001 : $past(s.count) - 32'h0000_0001))
    else $error("count step wrong");

  a_count_idle: assert property (!s.loaded && !z_rise |=> $stable(s.count))
    else $error("count moved before preset");

  a_preset_load: assert property (z_rise |=> s.loaded && s.count == $past(s.preset))
    else $error("preset not loaded");

  a_capture_copy: assert property (cap_hit |=> s.capt == $past(cur) && s.stat[ST_CAP])
    else $error("capture value wrong");

  a_capture_edge: assert property ($rose(cap_in) && s.ctrl[CTRL_EDGE_LO +: 2] == EDGE_FALL |-> !cap_hit)
    else $error("capture on wrong edge");

  a_reset_mode: assert property ($fell(rst) |-> s.ctrl[3:1] == 3'h0 && !s.ctrl[CTRL_MON])
    else $error("reset mode not normal x1");

  a_reset_mon: assert property ($fell(rst) ##1 !wr_en [*3] |-> !s.stat[ST_SUPPLY])
    else $error("supply monitor on after reset");

  a_filter_hold: assert property ($changed(s.fl[0]) |->
    $past(enc_a) == s.fl[0] && int'($past(s.fcnt[0])) + 1 >= filt_cyc($past(s.ctrl[CTRL_FILT_LO +: 4])))
    else $error("filter released early");

  a_x4_edges: assert property (s.ctrl[CTRL_MUL_LO +: 2] == MUL_X4 && $changed(s.fprev[1]) |->
    $past(step))
    else $error("x4 missed a B edge");

  sequence s_last_bit;
    s.ssi == SSI_HIGH && tick && s.bitn == 6'(FRAME_BITS - 1);
  endsequence

  sequence s_frame_end;
    s.ssi == SSI_GAP && s.sclk && s.stat[ST_FRAME];
  endsequence

  a_ssi_frame: assert property (s_last_bit |=> s_frame_end ##0 s.pos == $past(s.shreg))
    else $error("serial frame not stored");

  sequence s_bit_rise;
    abs_mode && s.ssi == SSI_LOW && tick;
  endsequence

  a_ssi_sample: assert property (s_bit_rise |=> ssi_clk && s.shreg[0] == $past(ssi_data))
    else $error("serial bit not taken on rising clock");

  a_ssi_parked: assert property (!abs_mode |=> ssi_clk)
    else $error("serial clock runs outside absolute mode");

  // Capture must neither add nor swallow a count step
  a_capture_undisturbed: assert property (cap_hit && !z_rise && !(active && step) |=> $stable(s.count))
    else $error("capture disturbed count");

  a_capture_fall: assert property ($fell(cap_in) && s.ctrl[CTRL_EDGE_LO +: 2] == EDGE_FALL |-> cap_hit)
    else $error("falling capture edge missed");

  a_capture_off: assert property (s.ctrl[CTRL_EDGE_LO +: 2] == 2'h3 |-> !cap_hit)
    else $error("capture while disabled");

  a_supply_flag: assert property (s.ctrl[CTRL_MON] && !supply_ok |=> s.stat[ST_SUPPLY])
    else $error("supply fault not flagged");

  a_monitor_off: assert property (!s.ctrl[CTRL_MON] && !s.stat[ST_SUPPLY] |=> !s.stat[ST_SUPPLY])
    else $error("supply flag set while monitor off");

endmodule : ecc_encoder_counter_capture

//--- verilog/ecc_pkg.sv
// Constants and types for the encoder counter with capture
package ecc_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int CLK_NS = 20;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESET = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CAPT = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // Control register fields
  localparam int CTRL_ABS = 0;
  localparam int CTRL_REV = 1;
  localparam int CTRL_MUL_LO = 2;
  localparam int CTRL_MON = 4;
  localparam int CTRL_EDGE_LO = 5;
  localparam int CTRL_INIT = 7;
  localparam int CTRL_FILT_LO = 8;
  localparam logic [31:0] CTRL_MASK = 32'h000F_FFFF;
  localparam logic [31:0] CTRL_RST = 32'h0002_2200;
  localparam logic [1:0] MUL_X1 = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h1;
  localparam logic [1:0] MUL_X4 = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Status and mask bits
  localparam int ST_W = 4;
  localparam int ST_CAP = 0;
  localparam int ST_PRESET = 1;
  localparam int ST_FRAME = 2;
  localparam int ST_SUPPLY = 3;
  // Filter times, least times rounded up
  localparam int FILT_1US_NS = 1000;
  localparam int FILT_2US_NS = 2000;
  localparam int FILT_5US_NS = 5000;
  localparam int FILT_50US_NS = 50000;
  localparam int FILT_10US_NS = 10000;
  localparam int FILT_80US_NS = 80000;
  localparam int FILT_500US_NS = 500000;
  localparam int FILT_1MS_NS = 1000000;
  localparam int FILT_1US_CYC = (FILT_1US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_2US_CYC = (FILT_2US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_5US_CYC = (FILT_5US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_50US_CYC = (FILT_50US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_10US_CYC = (FILT_10US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_80US_CYC = (FILT_80US_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_CNT_W = 16;
  // Serial link timing
  localparam int SSI_HZ = 250000;
  localparam int SSI_HALF_CYC = CLK_HZ / (2 * SSI_HZ);
  localparam int SSI_GAP_NS = 20000;
  localparam int SSI_GAP_CYC = (SSI_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SSI_DIV_W = 8;
  localparam int SSI_GAP_W = 11;
  typedef enum logic [3:0] {
    SSI_IDLE = 4'b0001,
    SSI_LOW = 4'b0010,
    SSI_HIGH = 4'b0100,
    SSI_GAP = 4'b1000
  } ecc_ssi_t;
endpackage : ecc_pkg

//--- testbench/ecc_enc_model.sv
// Behavioural quadrature and serial absolute position encoder
`timescale 1ns/100ps
module ecc_enc_model #(
  parameter int FB = 8
) (
  input wire logic clock,
  input wire logic ssi_clk,
  input wire logic [FB-1:0] ssi_pos,
  output logic enc_a,
  output logic enc_b,
  output logic ssi_data
);
  logic [1:0] phase = 2'h0;
  logic glitch = 1'b0;
  logic [FB-1:0] shadow = '0;
  int hi_cnt = 0;
  int idx = 0;
  // Gray order 00,10,11,01: A leads B when moving up
  assign enc_a = phase[0] ^ phase[1] ^ glitch;
  assign enc_b = phase[1];
  initial ssi_data = 1'b0;
  task automatic step(input bit up, input int hold);
    @(posedge clock);
    phase <= up ? phase + 2'h1 : phase - 2'h1;
    repeat (hold) @(posedge clock);
  endtask : step
  task automatic pulse_a(input int len);
    @(posedge clock);
    glitch <= 1'b1;
    repeat (len) @(posedge clock);
    glitch <= 1'b0;
  endtask : pulse_a
  always @(posedge clock) begin
    hi_cnt <= ssi_clk ? hi_cnt + 1 : 0;
    // Line released after the frame: toggle so a stale bit is never read as valid
    if (ssi_clk && hi_cnt > 150) ssi_data <= ~ssi_data;
  end
  // Long high time marks a new frame; position is frozen for the whole frame
  always @(negedge ssi_clk) begin
    if (hi_cnt > 300) begin
      shadow = ssi_pos;
      idx = FB - 1;
    end else begin
      idx = idx - 1;
    end
    ssi_data <= shadow[idx];
  end
endmodule : ecc_enc_model

//--- testbench/tb_encoder_counter_capture.sv
// Self-checking bench for the encoder counter with capture
`timescale 1ns/100ps
module tb_encoder_counter_capture;
  import ecc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic enc_z = 1'b0;
  logic cap_in = 1'b0;
  logic supply_ok = 1'b1;
  logic [7:0] ssi_pos = 8'h00;
  logic [31:0] rdata, rv, cnt;
  logic irq, enc_a, enc_b, ssi_clk, ssi_data;
  logic [1:0] mul;
  bit up, rev;
  int errors = 0;
  int checks = 0;
  int seed, n;
  always #10 clock = ~clock;
  ecc_encoder_counter_capture #(.FRAME_BITS(8), .FILT_500US_CYC(20), .FILT_1MS_CYC(40))
    u_ecc_encoder_counter_capture (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq(irq), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .cap_in(cap_in), .supply_ok(supply_ok), .ssi_clk(ssi_clk), .ssi_data(ssi_data));
  ecc_enc_model #(.FB(8)) u_ecc_enc_model (.clock(clock), .ssi_clk(ssi_clk), .ssi_pos(ssi_pos),
    .enc_a(enc_a), .enc_b(enc_b), .ssi_data(ssi_data));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic z_pulse;
    @(posedge clock);
    enc_z <= 1'b1;
    repeat (4) @(posedge clock);
    enc_z <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : z_pulse
  function automatic int per_cycle(input logic [1:0] m);
    return (m == MUL_X4) ? 4 : (m == MUL_X2) ? 2 : 1;
  endfunction : per_cycle
  function automatic logic [31:0] cap_hit(input logic [1:0] c, input bit rising);
    return 32'((c == EDGE_BOTH) || (c == EDGE_RISE && rising) || (c == EDGE_FALL && !rising));
  endfunction : cap_hit
  function automatic logic [31:0] ctl_word(input bit r, input logic [1:0] m, input logic [1:0] e, input logic [3:0] f);
    return {12'h000, f, f, f, 1'b1, e, 1'b0, m, r, 1'b0};
  endfunction : ctl_word
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    // Whole run is a few thousand cycles; serial frame dominates
    repeat (20000) @(posedge clock);
    errors++;
    $display("CHECK FAILED at %0t ns: watchdog expired", $time);
    end_sim();
  end
  initial begin
    seed = $urandom(11);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CTRL, rv);
    chk(rv, CTRL_RST, "reset control");
    chk(32'(ssi_clk), 32'h0000_0001, "serial clock idle");
    rd(8'h18, rv);
    chk(rv, 32'h0000_0000, "unmapped read");
    wr(ADDR_CTRL, ctl_word(1'b0, MUL_X1, EDGE_FALL, 4'h0));
    repeat (4) u_ecc_enc_model.step(1'b1, 3);
    rd(ADDR_COUNT, rv);
    chk(rv, 32'h0000_0000, "count before preset");
    cnt = $urandom;
    wr(ADDR_PRESET, cnt);
    z_pulse();
    rd(ADDR_COUNT, rv);
    chk(rv, cnt, "preset load");
    rd(ADDR_STAT, rv);
    chk(rv & 32'h0000_0002, 32'h0000_0002, "preset flag");
    $display("Test preset done");
    for (int m = 0; m < 6; m++) begin
      rev = (m >= 3);
      mul = 2'(m % 3);
      n = 1 + $urandom_range(2);
      up = 1'($urandom_range(1));
      wr(ADDR_CTRL, ctl_word(rev, mul, EDGE_FALL, 4'h0));
      repeat (4 * n) u_ecc_enc_model.step(up, 3);
      repeat (4) @(posedge clock);
      cnt = (up ^ rev) ? cnt + 32'(n * per_cycle(mul)) : cnt - 32'(n * per_cycle(mul));
      rd(ADDR_COUNT, rv);
      chk(rv, cnt, "count after steps");
    end
    $display("Test modes done");
    wr(ADDR_MASK, 32'h0000_0001);
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CTRL, ctl_word(1'b0, MUL_X1, 2'(e), 4'h0));
      for (int r = 1; r >= 0; r--) begin
        wr(ADDR_STAT, 32'h0000_000F);
        @(posedge clock);
        cap_in <= r[0];
        repeat (3) @(posedge clock);
        chk(32'(irq), cap_hit(2'(e), r[0]), "capture interrupt");
        rd(ADDR_STAT, rv);
        chk(rv & 32'h0000_0001, cap_hit(2'(e), r[0]), "capture flag");
      end
    end
    rd(ADDR_CAPT, rv);
    chk(rv, cnt, "captured count");
    repeat (4) u_ecc_enc_model.step(1'b1, 3);
    repeat (4) @(posedge clock);
    rd(ADDR_COUNT, rv);
    chk(rv, cnt + 32'h0000_0001, "count after capture");
    rd(ADDR_CAPT, rv);
    chk(rv, cnt, "capture held");
    cnt = cnt + 32'h0000_0001;
    $display("Test capture done");
    // Filter of 1 us on all inputs, x4 so a single A edge shows
    wr(ADDR_CTRL, ctl_word(1'b0, MUL_X4, 2'h3, 4'h1));
    fork
      u_ecc_enc_model.pulse_a(FILT_1US_CYC - 5);
      begin
        repeat (20) @(posedge clock);
        rd(ADDR_COUNT, rv);
      end
    join
    chk(rv, cnt, "short glitch ignored");
    fork
      u_ecc_enc_model.step(1'b1, FILT_1US_CYC + 30);
      begin
        repeat (FILT_1US_CYC - 10) @(posedge clock);
        rd(ADDR_COUNT, rv);
        chk(rv, cnt, "edge still filtered");
        repeat (15) @(posedge clock);
        rd(ADDR_COUNT, rv);
        chk(rv, cnt + 32'h0000_0001, "edge passed filter");
      end
    join
    repeat (3) u_ecc_enc_model.step(1'b1, FILT_1US_CYC + 10);
    cnt = cnt + 32'h0000_0004;
    rd(ADDR_COUNT, rv);
    chk(rv, cnt, "filtered steps");
    // 500 us code, shortened to 20 cycles by the override above
    wr(ADDR_CTRL, ctl_word(1'b0, MUL_X4, 2'h3, 4'h7));
    u_ecc_enc_model.pulse_a(15);
    repeat (25) @(posedge clock);
    rd(ADDR_COUNT, rv);
    chk(rv, cnt, "long filter glitch");
    u_ecc_enc_model.step(1'b1, 25);
    rd(ADDR_COUNT, rv);
    chk(rv, cnt + 32'h0000_0001, "long filter edge");
    cnt = cnt + 32'h0000_0001;
    $display("Test filter done");
    @(posedge clock);
    supply_ok <= 1'b0;
    wr(ADDR_STAT, 32'h0000_000F);
    rd(ADDR_STAT, rv);
    chk(rv & 32'h0000_0008, 32'h0000_0000, "monitor off");
    wr(ADDR_MASK, 32'h0000_0008);
    wr(ADDR_CTRL, ctl_word(1'b0, MUL_X1, 2'h3, 4'h0) | 32'h0000_0010);
    repeat (3) @(posedge clock);
    chk(32'(irq), 32'h0000_0001, "supply fault interrupt");
    supply_ok <= 1'b1;
    wr(ADDR_STAT, 32'h0000_0008);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0000_0000, "supply fault cleared");
    $display("Test supply done");
    ssi_pos <= 8'($urandom);
    wr(ADDR_CTRL, ctl_word(1'b0, MUL_X1, 2'h3, 4'h0) | 32'h0000_0001);
    wr(ADDR_STAT, 32'h0000_000F);
    n = 0;
    rv = 32'h0000_0000;
    while (rv[ST_FRAME] !== 1'b1 && n < 2000) begin
      rd(ADDR_STAT, rv);
      n++;
    end
    chk(32'(rv[ST_FRAME]), 32'h0000_0001, "frame done flag");
    rd(ADDR_COUNT, rv);
    chk(rv, {24'h00_0000, ssi_pos}, "serial position");
    $display("Test serial done");
    end_sim();
  end
endmodule : tb_encoder_counter_capture
